/* File: rtl/emsc_cfg.svh */
// Constants for the external memory strobe control block.
// Assumes inclusion by bare name from design and bench files.
`ifndef EMSC_CFG_SVH
`define EMSC_CFG_SVH
`define EMSC_PHASES_X12 4'hC
`define EMSC_PHASES_X6 4'h6
`define EMSC_RST_CYCLES 2'h2
`define EMSC_RST_HOLD_CLKS 5'h18
`define EMSC_ALE1_POS_X12 4'h0
`define EMSC_ALE2_POS_X12 4'h6
`define EMSC_PSEN1_POS_X12 4'h2
`define EMSC_PSEN2_POS_X12 4'h8
`define EMSC_STROBE_LEN_X12 4'h2
`endif

/* File: rtl/emsc_phase_gen.sv */
// Machine cycle phase counter.
// Assumes a synchronous core reset.
`timescale 1ns/1ps
`include "emsc_cfg.svh"
module emsc_phase_gen (
  input wire logic mclk_i,     // Oscillator clock.
  input wire logic rst_i,      // Async reset.
  input wire logic core_rst_i, // Sync core reset.
  input wire logic x6_i,       // Six-clock mode.
  output logic [3:0] phase_o,  // Phase in machine cycle.
  output logic last_o          // Final phase of cycle.
);
  wire [3:0] len = x6_i ? `EMSC_PHASES_X6 : `EMSC_PHASES_X12;
  assign last_o = (phase_o == 4'(len - 4'h1));
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_o <= 4'h0;
    end else if (core_rst_i || last_o) begin
      phase_o <= 4'h0;
    end else begin
      phase_o <= 4'(phase_o + 4'h1);
    end
  end
endmodule : emsc_phase_gen

/* File: rtl/emsc_pkg.sv */
// Types for the external memory strobe control block.
// Assumes emsc_cfg.svh is on the include path.
package emsc_pkg;
  typedef enum logic [1:0] {
    EMSC_ACC_NONE,
    EMSC_ACC_READ,
    EMSC_ACC_WRITE
  } emsc_acc_t;
endpackage : emsc_pkg

/* File: rtl/emsc_reset_filter.sv */
// Reset qualifier: reset input must stay high for two machine cycles.
// Assumes the reset request is synchronous to mclk_i.
`timescale 1ns/1ps
`include "emsc_cfg.svh"
module emsc_reset_filter (
  input wire logic mclk_i,  // Oscillator clock.
  input wire logic rst_i,   // Async power-on reset.
  input wire logic req_i,   // Reset pin level.
  input wire logic x6_i,    // Six-clock mode.
  output logic core_rst_o   // Qualified core reset.
);
  logic [4:0] cnt_q;
  // Widen both factors first so the product does not wrap in four bits.
  wire [4:0] need = x6_i ? 5'(5'(`EMSC_RST_CYCLES) * 5'(`EMSC_PHASES_X6))
                         : 5'(5'(`EMSC_RST_CYCLES) * 5'(`EMSC_PHASES_X12));
  wire done = (cnt_q >= need);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 5'h00;
      core_rst_o <= 1'b1;
    end else begin
      cnt_q <= req_i ? (done ? cnt_q : 5'(cnt_q + 5'h01)) : 5'h00;
      if (req_i && done) begin
        core_rst_o <= 1'b1;
      end else if (!req_i) begin
        core_rst_o <= 1'b0;
      end
    end
  end
endmodule : emsc_reset_filter

/* File: rtl/emsc_top.sv */
// Strobe generator for the external program and data memory bus.
// Assumes a core supplies access requests aligned to machine cycles.
// Operation
// - Internal fetch keeps fetch strobe high
// - External fetch: two fetch strobes per cycle
// - Data access skips two fetch strobes
// - Reset high two machine cycles resets
// - Select low fetches externally, high internally
// - Latch strobe marks each external access
// - Twelve-clock latch strobe at one sixth
// - Data access drops one latch pulse
// - Latch-strobe-off bit stops latch strobe
// - Six-clock latch strobe at one third
// - Port 3 bit 6 is write strobe
// - Port 3 bit 7 is read strobe
`timescale 1ns/1ps
`include "emsc_cfg.svh"
module emsc_top (
  input wire logic mclk_i,                    // Oscillator input clock.
  input wire logic rst_i,                     // Async reset, active high.
  input wire logic reset_pin_i,               // Device reset pin level.
  input wire logic external_fetch_select_n_i, // Low selects external code.
  input wire logic x6_mode_i,                 // Six-clock mode select.
  input wire logic latch_strobe_off_i,        // Latch strobe disable bit.
  input wire emsc_pkg::emsc_acc_t data_acc_i, // Data access for next cycle.
  output logic program_fetch_strobe_n_o,      // Code read strobe, low active.
  output logic addr_latch_strobe_o,           // Address latch strobe.
  output logic p3_6_wr_n_o,                   // Data write strobe, low active.
  output logic p3_7_rd_n_o,                   // Data read strobe, low active.
  output logic core_reset_o,                  // Qualified core reset.
  output logic data_cycle_o                   // Data cycle in progress.
);
  import emsc_pkg::*;

  // ==========================================================
  // Timing base
  // ==========================================================
  logic core_rst;
  logic [3:0] phase;
  logic last;
  emsc_reset_filter u_rst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .req_i(reset_pin_i),
    .x6_i(x6_mode_i),
    .core_rst_o(core_rst)
  );
  emsc_phase_gen u_phase (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .core_rst_i(core_rst),
    .x6_i(x6_mode_i),
    .phase_o(phase),
    .last_o(last)
  );

  // ==========================================================
  // Cycle type
  // ==========================================================
  emsc_acc_t acc_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= EMSC_ACC_NONE;
    end else if (core_rst) begin
      acc_q <= EMSC_ACC_NONE;
    end else if (last) begin
      acc_q <= data_acc_i;
    end
  end

  // In six-clock mode all positions halve.
  wire [3:0] ale1 = x6_mode_i ? (`EMSC_ALE1_POS_X12 >> 1) : `EMSC_ALE1_POS_X12;
  wire [3:0] ale2 = x6_mode_i ? (`EMSC_ALE2_POS_X12 >> 1) : `EMSC_ALE2_POS_X12;
  wire [3:0] ps1 = x6_mode_i ? (`EMSC_PSEN1_POS_X12 >> 1) : `EMSC_PSEN1_POS_X12;
  wire [3:0] ps2 = x6_mode_i ? (`EMSC_PSEN2_POS_X12 >> 1) : `EMSC_PSEN2_POS_X12;
  wire [3:0] slen = x6_mode_i ? (`EMSC_STROBE_LEN_X12 >> 1) : `EMSC_STROBE_LEN_X12;
  wire data_cyc = (acc_q != EMSC_ACC_NONE);
  wire ext_fetch = !external_fetch_select_n_i;

  wire in_ps1 = (phase >= ps1) && (phase < 4'(ps1 + slen));
  wire in_ps2 = (phase >= ps2) && (phase < 4'(ps2 + slen));
  // Both fetch strobes are skipped in a data cycle.
  wire program_fetch_strobe_d = !(ext_fetch && !data_cyc && (in_ps1 || in_ps2));

  // Second latch pulse is dropped in a data cycle; first latches the data address.
  wire ale_a = (phase == ale1);
  wire ale_b = (phase == ale2) && !data_cyc;
  wire ale_d = !latch_strobe_off_i && (ale_a || ale_b);

  // Data strobe starts at the second latch position and lasts two strobe lengths.
  wire half = (phase >= ale2) && (phase < 4'(ale2 + slen + slen));
  wire wr_d = !((acc_q == EMSC_ACC_WRITE) && half);
  wire rd_d = !((acc_q == EMSC_ACC_READ) && half);

  // ==========================================================
  // Output registers
  // ==========================================================
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      program_fetch_strobe_n_o <= 1'b1;
      addr_latch_strobe_o <= 1'b0;
      p3_6_wr_n_o <= 1'b1;
      p3_7_rd_n_o <= 1'b1;
      core_reset_o <= 1'b1;
      data_cycle_o <= 1'b0;
    end else begin
      program_fetch_strobe_n_o <= core_rst ? 1'b1 : program_fetch_strobe_d;
      addr_latch_strobe_o <= core_rst ? 1'b0 : ale_d;
      p3_6_wr_n_o <= core_rst ? 1'b1 : wr_d;
      p3_7_rd_n_o <= core_rst ? 1'b1 : rd_d;
      core_reset_o <= core_rst;
      data_cycle_o <= data_cyc;
    end
  end
endmodule : emsc_top

/* File: tb/emsc_mem_model.sv */
// External memory bus model; counts each strobe it sees.
// Assumes clr_i is driven away from the rising edge.
`timescale 1ns/1ps
module emsc_mem_model (
  input wire logic mclk_i, clr_i, ale_i, program_fetch_strobe_n_i, rd_n_i, wr_n_i, // Bus side.
  output logic [31:0] cnt_o // Latch, fetch, read, write counts.
);
  logic [3:0] s_q;
  wire logic [3:0] s = {ale_i, ~program_fetch_strobe_n_i, ~rd_n_i, ~wr_n_i};
  // Each counter counts every leading edge of its strobe.
  always_ff @(posedge mclk_i) begin
    s_q <= s;
    for (int i = 0; i < 4; i++) begin
      cnt_o[8*i+:8] <= clr_i ? 8'h00 : cnt_o[8*i+:8] + {7'h0, s[i] & ~s_q[i]};
    end
  end
endmodule : emsc_mem_model

/* File: tb/emsc_monitor.sv */
// Checker for the strobe timing of emsc_top.
// Bound to every emsc_top instance; sees only its ports.
`timescale 1ns/1ps
module emsc_monitor (
  input wire logic mclk_i, rst_i, x6_mode_i, latch_strobe_off_i, // Clock, reset, modes.
  input wire logic external_fetch_select_n_i, program_fetch_strobe_n_o, // Fetch.
  input wire logic addr_latch_strobe_o, p3_6_wr_n_o, p3_7_rd_n_o, // Strobes.
  input wire logic core_reset_o, data_cycle_o // Status.
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i || core_reset_o);
  property p_int; external_fetch_select_n_i[*3] |-> program_fetch_strobe_n_o; endproperty
  a_int: assert property (p_int) else $error("fetch strobe in internal mode");
  property p_flen; $fell(program_fetch_strobe_n_o) && !x6_mode_i
    |=> !program_fetch_strobe_n_o ##1 program_fetch_strobe_n_o; endproperty
  a_flen: assert property (p_flen) else $error("fetch strobe length");
  property p_skip; data_cycle_o |-> program_fetch_strobe_n_o; endproperty
  a_skip: assert property (p_skip) else $error("fetch strobe in data cycle");
  property p_a12; addr_latch_strobe_o && !x6_mode_i |=> !addr_latch_strobe_o[*5]; endproperty
  a_a12: assert property (p_a12) else $error("latch strobe spacing");
  property p_a6; addr_latch_strobe_o && x6_mode_i |=> !addr_latch_strobe_o[*2]; endproperty
  a_a6: assert property (p_a6) else $error("latch strobe spacing six");
  property p_off; latch_strobe_off_i[*3] |-> !addr_latch_strobe_o; endproperty
  a_off: assert property (p_off) else $error("latch strobe while off");
  property p_wr; !p3_6_wr_n_o |-> data_cycle_o && p3_7_rd_n_o; endproperty
  a_wr: assert property (p_wr) else $error("write strobe");
  property p_rd; !p3_7_rd_n_o |-> data_cycle_o && p3_6_wr_n_o; endproperty
  a_rd: assert property (p_rd) else $error("read strobe");
  c_rd: cover property (!p3_7_rd_n_o);
  c_wr: cover property (!p3_6_wr_n_o);
  c_six: cover property (addr_latch_strobe_o && x6_mode_i);
endmodule : emsc_monitor
bind emsc_top emsc_monitor u_emsc_monitor (.*);

/* File: tb/tb_top.sv */
// Random windows of steady traffic; strobe counts are checked per window.
`timescale 1ns/1ps
module tb_top;
  import emsc_pkg::*;
  logic mclk_i = 0, rst_i = 1, pin = 0, ext_n = 0, x6 = 0, off = 0, clr = 0, d;
  logic program_fetch_strobe, ale, wr, rd, crst, dc;
  emsc_acc_t acc = EMSC_ACC_NONE;
  logic [31:0] cnt, res, q[$], rng = 13589;
  int bad_count = 0, checks_done = 0;
  event rdy;
  always #25 mclk_i = ~mclk_i;
  emsc_top u_emsc_top (.mclk_i, .rst_i, .reset_pin_i(pin), .external_fetch_select_n_i(ext_n),
    .x6_mode_i(x6), .latch_strobe_off_i(off), .data_acc_i(acc), .program_fetch_strobe_n_o(program_fetch_strobe),
    .addr_latch_strobe_o(ale), .p3_6_wr_n_o(wr), .p3_7_rd_n_o(rd), .core_reset_o(crst),
    .data_cycle_o(dc));
  emsc_mem_model u_emsc_mem_model (.mclk_i, .clr_i(clr), .ale_i(ale), .program_fetch_strobe_n_i(program_fetch_strobe),
    .rd_n_i(rd), .wr_n_i(wr), .cnt_o(cnt));
  task automatic win(logic [31:0] e);
    // Keeps each window a whole number of machine cycles, so inputs change in the last phase.
    repeat (x6 ? 11 : 23) @(negedge mclk_i);
    clr = 1;
    @(negedge mclk_i) clr = 0;
    q.push_back(e);
    repeat (x6 ? 24 : 48) @(negedge mclk_i);
    res = cnt;
    ->rdy;
  endtask : win
  task automatic run(int k);
    repeat (k) begin
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      ext_n = rng[0];
      off = rng[1] & rng[4];
      acc = emsc_acc_t'(rng[3:2] % 2'h3);
      d = acc != EMSC_ACC_NONE;
      win({off ? 8'h00 : d ? 8'h04 : 8'h08, ext_n | d ? 8'h00 : 8'h08,
        acc == EMSC_ACC_READ ? 8'h04 : 8'h00, acc == EMSC_ACC_WRITE ? 8'h04 : 8'h00});
    end
  endtask : run
  task automatic rpin(int n, logic e);
    pin = 1;
    repeat (n) @(negedge mclk_i);
    q.push_back({31'h0, e});
    res = {31'h0, crst};
    ->rdy;
    pin = 0;
  endtask : rpin
  task automatic end_sim;
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  always @(rdy) begin
    checks_done++;
    if (res !== q[0]) begin
      bad_count++;
      $display("mismatch strobe counts exp %h got %h", q[0], res);
    end
    void'(q.pop_front());
  end
  initial begin
    repeat (6) @(negedge mclk_i);
    rst_i = 0;
    run(12);
    rpin(10, 1'b0);
    rpin(26, 1'b1);
    x6 = 1;
    rst_i = 1;
    @(negedge mclk_i) rst_i = 0;
    run(8);
    end_sim;
  end
  // Twenty windows need about 1200 clocks; allow some four times that.
  initial begin
    #250us;
    bad_count++;
    end_sim;
  end
endmodule : tb_top
